/* rtl/sft_pkg.sv */
package sft_pkg;
    // register interface: index/data port pair
    localparam logic       PORT_INDEX      = 1'b0;
    localparam logic       PORT_DATA       = 1'b1;
    localparam int         IDX_W           = 7;
    localparam int         NUM_FANS        = 2;
    // bank numbers
    localparam logic [2:0] BANK_MAIN       = 3'h0;
    localparam logic [2:0] BANK_PRIMARY    = 3'h1;
    localparam logic [2:0] BANK_AUX        = 3'h2;
    // register offsets, bank 0 unless noted
    localparam logic [6:0] OFS_BANK_SEL    = 7'h4e;
    localparam logic [6:0] OFS_CTRL_EN     = 7'h6b;
    localparam logic [6:0] OFS_STEP_DOWN   = 7'h0e;
    localparam logic [6:0] OFS_STEP_UP     = 7'h0f;
    localparam logic [6:0] OFS_KEEP_MIN    = 7'h12;
    localparam logic [6:0] OFS_SYS_TEMP    = 7'h27;
    localparam logic [6:0] OFS_SEL_A       = 7'h49;
    localparam logic [6:0] OFS_SEL_B       = 7'h4a;
    localparam logic [6:0] OFS_TEMP_WHOLE  = 7'h50;  // banks 1 and 2
    localparam logic [6:0] OFS_TEMP_HALF   = 7'h51;  // banks 1 and 2
    // per-fan offsets, index 0 = fan a, index 1 = fan b
    localparam logic [6:0] OFS_OUT   [NUM_FANS] = '{7'h03, 7'h61};
    localparam logic [6:0] OFS_TARGET[NUM_FANS] = '{7'h06, 7'h63};
    localparam logic [6:0] OFS_TOL   [NUM_FANS] = '{7'h07, 7'h62};
    localparam logic [6:0] OFS_STOPV [NUM_FANS] = '{7'h09, 7'h64};
    localparam logic [6:0] OFS_STOPT [NUM_FANS] = '{7'h0d, 7'h66};
    localparam logic [6:0] OFS_MAX   [NUM_FANS] = '{7'h67, 7'h69};
    localparam logic [6:0] OFS_STEP  [NUM_FANS] = '{7'h68, 7'h6a};
    // field positions
    localparam int         TOL_LSB   [NUM_FANS] = '{4, 0};
    localparam int         KEEP_BIT  [NUM_FANS] = '{4, 6};
    localparam int         SEL_LSB   [NUM_FANS] = '{0, 5};
    // sensor select encodings
    localparam logic [2:0] SENS_SYSTEM     = 3'h0;
    localparam logic [2:0] SENS_PRIMARY    = 3'h1;
    localparam logic [2:0] SENS_AUX        = 3'h2;
    // reset values
    localparam logic [7:0] OUT_STRAP_LO    = 8'h80;
    localparam logic [7:0] OUT_STRAP_HI    = 8'hff;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_MAX         = 8'hff;
    localparam logic [7:0] RST_STEP        = 8'h01;
    // step-time unit
    localparam int         CLK_MHZ         = 100;
    localparam int         STEP_UNIT_MS    = 100;
    localparam int         STEP_UNIT_CYC   = STEP_UNIT_MS * 1000 * CLK_MHZ;
endpackage

/* rtl/sft_fan_ctrl.sv */
`timescale 1ns/1ps
module sft_fan_ctrl
    import sft_pkg::*;
#(
    parameter int TICK_CYCLES = STEP_UNIT_CYC          // clocks per step-time unit
) (
    input  wire logic       sys_clk,                   // system clock, 100 MHz
    input  wire logic       srst,                      // synchronous reset, high
    input  wire logic       host_wr,                   // write strobe, one cycle
    input  wire logic       host_rd,                   // read strobe, one cycle
    input  wire logic       host_port_sel,             // 0 index port, 1 data port
    input  wire logic [7:0] host_wdata,                // write data
    output logic      [7:0] host_rdata,                // read data, valid cycle after rd
    input  wire logic [7:0] system_temp_input,         // system sensor, whole degrees
    input  wire logic [8:0] primary_temp_input,        // primary sensor, msb whole, lsb half
    input  wire logic [8:0] auxiliary_temp_input,      // aux sensor, msb whole, lsb half
    input  wire logic       out_strap,                 // strap: 1 starts outputs at full
    output logic      [7:0] fan_output_a,              // fan a drive value
    output logic      [7:0] fan_output_b               // fan b drive value
);
    // refuse a prescaler that could never produce a tick
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least one");
    end

    // prescaler width, sized so the terminal count always fits
    localparam int TW = $clog2(TICK_CYCLES + 1);

    // limitation: one prescaler serves both fans, so their steps line up in time
    // shared state
    logic [6:0]    idx_q, idx_d;                       // index pointer
    logic [2:0]    bank_q, bank_d;                     // bank select
    logic [7:0]    rdata_q, rdata_d;                   // registered read data
    logic [7:0]    sdown_q, sdown_d;                   // step-down interval
    logic [7:0]    sup_q, sup_d;                       // step-up interval
    logic [7:0]    keep_q, keep_d;                     // keep-minimum enables
    logic [7:0]    sel_q[NUM_FANS], sel_d[NUM_FANS];   // sensor select registers
    logic [1:0]    en_q, en_d;                         // regulation enables
    logic [TW-1:0] pre_q, pre_d;                       // step-unit prescaler
    logic          tick;                               // one-cycle step-unit pulse
    logic          init_q, init_d;                     // strap sampled since reset
    logic          wr_data;                            // data port write
    // per-fan registers, written by software or stepped by hardware
    logic [7:0]    out_q[NUM_FANS];
    logic [7:0]    tgt_q[NUM_FANS];
    logic [7:0]    tol_q[NUM_FANS];
    logic [7:0]    stopv_q[NUM_FANS];
    logic [7:0]    stopt_q[NUM_FANS];
    logic [7:0]    max_q[NUM_FANS];
    logic [7:0]    step_q[NUM_FANS];

    // only data-port writes reach the register map; index writes move the pointer
    assign wr_data = host_wr && (host_port_sel == PORT_DATA);
    // one tick per step unit; every interval and stop time counts these
    assign tick    = (pre_q == TW'(TICK_CYCLES - 1));

    // true when the data port write hits a bank-0 index
    function automatic logic hit(input logic [6:0] ofs, input logic [6:0] idx, input logic [2:0] bnk,
                                 input logic we);
        hit = we && (bnk == BANK_MAIN) && (idx == ofs);
    endfunction

    // sensor select decoding, shared by both fans; unused codes fall back to system
    function automatic logic [7:0] pick_temp(input logic [2:0] sel, input logic [7:0] sys_t,
                                             input logic [8:0] pri_t, input logic [8:0] aux_t);
        case (sel)
            SENS_PRIMARY: pick_temp = pri_t[8:1];
            SENS_AUX:     pick_temp = aux_t[8:1];
            default:      pick_temp = sys_t;
        endcase
    endfunction

    // read mux over the banked map
    function automatic logic [7:0] read_reg(input logic [6:0] idx, input logic [2:0] bnk);
        read_reg = 8'h00;                              // unmapped reads give zero
        // banks 1 and 2 hold the two half-degree sensors
        if (bnk == BANK_PRIMARY) begin
            if (idx == OFS_TEMP_WHOLE) read_reg = primary_temp_input[8:1];
            if (idx == OFS_TEMP_HALF)  read_reg = {primary_temp_input[0], 7'h00};
        end else if (bnk == BANK_AUX) begin
            if (idx == OFS_TEMP_WHOLE) read_reg = auxiliary_temp_input[8:1];
            if (idx == OFS_TEMP_HALF)  read_reg = {auxiliary_temp_input[0], 7'h00};
        end else if (bnk == BANK_MAIN) begin
            // bank 0: configuration and per-fan registers
            if (idx == OFS_STEP_DOWN) read_reg = sdown_q;
            if (idx == OFS_STEP_UP)   read_reg = sup_q;
            if (idx == OFS_KEEP_MIN)  read_reg = keep_q;
            if (idx == OFS_SYS_TEMP)  read_reg = system_temp_input;
            if (idx == OFS_SEL_A)     read_reg = sel_q[0];
            if (idx == OFS_SEL_B)     read_reg = sel_q[1];
            if (idx == OFS_CTRL_EN)   read_reg = {6'h00, en_q};
            // per-fan registers sit at scattered offsets, so search both fans
            for (int f = 0; f < NUM_FANS; f++) begin
                if (idx == OFS_OUT[f])    read_reg = out_q[f];
                if (idx == OFS_TARGET[f]) read_reg = tgt_q[f];
                if (idx == OFS_TOL[f])    read_reg = tol_q[f];
                if (idx == OFS_STOPV[f])  read_reg = stopv_q[f];
                if (idx == OFS_STOPT[f])  read_reg = stopt_q[f];
                if (idx == OFS_MAX[f])    read_reg = max_q[f];
                if (idx == OFS_STEP[f])   read_reg = step_q[f];
            end
        end
    endfunction

    // shared registers: port, configuration, prescaler
    always_comb begin
        idx_d   = idx_q;
        bank_d  = bank_q;
        rdata_d = rdata_q;
        sdown_d = sdown_q;
        sup_d   = sup_q;
        keep_d  = keep_q;
        sel_d   = sel_q;
        en_d    = en_q;
        // the strap is taken on the first clock after reset, never during it
        init_d  = 1'b1;
        pre_d   = tick ? '0 : pre_q + TW'(1);
        // an index port write moves the pointer
        if (host_wr && host_port_sel == PORT_INDEX) begin
            idx_d = host_wdata[6:0];                   // bit 7 of the index port is reserved
        end
        // read data is captured once and held until the next read
        if (host_rd) begin
            rdata_d = (host_port_sel == PORT_INDEX) ? {1'b0, idx_q} : read_reg(idx_q, bank_q);
        end
        // the bank select lives in every bank so software can always get back
        if (wr_data && idx_q == OFS_BANK_SEL) bank_d = host_wdata[2:0];
        // bank-0 configuration writes
        if (hit(OFS_STEP_DOWN, idx_q, bank_q, wr_data)) sdown_d = host_wdata;
        if (hit(OFS_STEP_UP, idx_q, bank_q, wr_data))   sup_d = host_wdata;
        if (hit(OFS_KEEP_MIN, idx_q, bank_q, wr_data))  keep_d = host_wdata;
        if (hit(OFS_SEL_A, idx_q, bank_q, wr_data))     sel_d[0] = host_wdata;
        if (hit(OFS_SEL_B, idx_q, bank_q, wr_data))     sel_d[1] = host_wdata;
        if (hit(OFS_CTRL_EN, idx_q, bank_q, wr_data))   en_d = host_wdata[1:0];
    end

    // shared registers and prescaler; srst is sampled like any other input
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            idx_q   <= '0;
            bank_q  <= BANK_MAIN;
            rdata_q <= RST_ZERO;
            sdown_q <= RST_ZERO;
            sup_q   <= RST_ZERO;
            keep_q  <= RST_ZERO;
            sel_q   <= '{RST_ZERO, RST_ZERO};
            en_q    <= 2'b00;                          // regulation off until software sets up
            init_q  <= 1'b0;
            pre_q   <= '0;
        end else begin
            idx_q   <= idx_d;
            bank_q  <= bank_d;
            rdata_q <= rdata_d;
            sdown_q <= sdown_d;
            sup_q   <= sup_d;
            keep_q  <= keep_d;
            sel_q   <= sel_d;
            en_q    <= en_d;
            init_q  <= init_d;
            pre_q   <= pre_d;
        end
    end

    // outputs come straight from flops, so the fan drive never glitches
    assign host_rdata   = rdata_q;
    assign fan_output_a = out_q[0];
    assign fan_output_b = out_q[1];

    // one regulator per fan output
    for (genvar f = 0; f < NUM_FANS; f++) begin : g_fan
        // next values of the software-visible per-fan registers
        logic [7:0] out_d, tgt_d, tol_d, stopv_d, stopt_d, max_d, step_d;
        logic [7:0] upc_q, upc_d, dnc_q, dnc_d, stc_q, stc_d;  // pacing and stop timers
        logic [7:0] temp;                                      // selected sensor, whole degrees
        logic [3:0] tol;                                       // tolerance field
        logic [8:0] hi_lim, lo_sum, up_sum;
        logic       hot, cold;

        // whole degrees only: the half-degree bit would make the loop chatter
        assign temp   = pick_temp(sel_q[f][SEL_LSB[f] +: 3], system_temp_input,
                                  primary_temp_input, auxiliary_temp_input);
        assign tol    = tol_q[f][TOL_LSB[f] +: 4];
        // nine-bit sums keep the band edges from wrapping at 255
        assign hi_lim = {1'b0, tgt_q[f]} + {5'h00, tol};
        assign lo_sum = {1'b0, temp} + {5'h00, tol};
        // step-up result before the clamp to the maximum
        assign up_sum = {1'b0, out_q[f]} + {1'b0, step_q[f]};
        // strictly above the band edge; equal counts as in band
        assign hot    = {1'b0, temp} > hi_lim;
        // compared as temp + tol < target so nothing wraps below zero
        assign cold   = lo_sum < {1'b0, tgt_q[f]};

        // regulator: at most one up or down step per tick, gated by pacing counters; turn-off follows the stop timer unless the keep-minimum bit is set
        // a disabled fan freezes its output and target, so software owns them
        always_comb begin
            out_d   = out_q[f];
            tgt_d   = tgt_q[f];
            tol_d   = tol_q[f];
            stopv_d = stopv_q[f];
            stopt_d = stopt_q[f];
            max_d   = max_q[f];
            step_d  = step_q[f];
            // pacing counters saturate so a long wait never wraps back to zero
            upc_d   = (tick && upc_q != 8'hff) ? upc_q + 8'h01 : upc_q;
            dnc_d   = (tick && dnc_q != 8'hff) ? dnc_q + 8'h01 : dnc_q;
            stc_d   = stc_q;
            if (!init_q) begin
                // first clock after reset: load the strapped start value
                out_d = out_strap ? OUT_STRAP_HI : OUT_STRAP_LO;
            end else if (!en_q[f]) begin
                // regulation off: keep the counters clean for a fresh start
                upc_d = 8'h00;
                dnc_d = 8'h00;
                stc_d = 8'h00;
            end else if (hot) begin
                // too hot: the down and stop timers restart from zero
                dnc_d = 8'h00;
                stc_d = 8'h00;
                // step only when paced and still below the maximum
                if (tick && upc_q >= sup_q && out_q[f] < max_q[f]) begin
                    out_d = (up_sum > {1'b0, max_q[f]}) ? max_q[f] : up_sum[7:0];
                    tgt_d = hi_lim[8] ? 8'hff : hi_lim[7:0];
                    upc_d = 8'h00;
                end
            end else if (cold) begin
                // too cold: no upward pacing survives a cold spell
                upc_d = 8'h00;
                if (out_q[f] > stopv_q[f]) begin
                    stc_d = 8'h00;
                    // step only once the down interval has passed
                    if (tick && dnc_q >= sdown_q) begin
                        // never step below the stop value in one move
                        out_d = (out_q[f] - stopv_q[f] > step_q[f]) ?
                                out_q[f] - step_q[f] : stopv_q[f];
                        tgt_d = tgt_q[f] - {4'h0, tol};
                        dnc_d = 8'h00;
                    end
                end else if (!keep_q[KEEP_BIT[f]] && out_q[f] != 8'h00) begin
                    // parked at the stop value: wait out the stop time, then turn off
                    if (tick) stc_d = stc_q + 8'h01;
                    // a stop time of zero turns the fan off on the next clock
                    if (stc_q >= stopt_q[f]) begin
                        out_d = 8'h00;
                        stc_d = 8'h00;
                    end
                end
            end else begin
                // in band: hold the output and restart every timer
                upc_d = 8'h00;
                dnc_d = 8'h00;
                stc_d = 8'h00;
            end
            // software writes win over the regulator in the same cycle
            if (hit(OFS_OUT[f], idx_q, bank_q, wr_data))    out_d = host_wdata;
            if (hit(OFS_TARGET[f], idx_q, bank_q, wr_data)) tgt_d = host_wdata;
            if (hit(OFS_TOL[f], idx_q, bank_q, wr_data))    tol_d = host_wdata;
            if (hit(OFS_STOPV[f], idx_q, bank_q, wr_data))  stopv_d = host_wdata;
            if (hit(OFS_STOPT[f], idx_q, bank_q, wr_data))  stopt_d = host_wdata;
            if (hit(OFS_MAX[f], idx_q, bank_q, wr_data))    max_d = host_wdata;
            if (hit(OFS_STEP[f], idx_q, bank_q, wr_data))   step_d = host_wdata;
        end

        // per-fan registers; max and step reset to usable values so an unset fan still moves
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                out_q[f]   <= OUT_STRAP_LO;
                tgt_q[f]   <= RST_ZERO;
                tol_q[f]   <= RST_ZERO;
                stopv_q[f] <= RST_ZERO;
                stopt_q[f] <= RST_ZERO;
                max_q[f]   <= RST_MAX;
                step_q[f]  <= RST_STEP;
                upc_q      <= 8'h00;
                dnc_q      <= 8'h00;
                stc_q      <= 8'h00;
            end else begin
                out_q[f]   <= out_d;
                tgt_q[f]   <= tgt_d;
                tol_q[f]   <= tol_d;
                stopv_q[f] <= stopv_d;
                stopt_q[f] <= stopt_d;
                max_q[f]   <= max_d;
                step_q[f]  <= step_d;
                upc_q      <= upc_d;
                dnc_q      <= dnc_d;
                stc_q      <= stc_d;
            end
        end
    end
endmodule

/* test/sft_fan_ctrl_props.sv */
`timescale 1ns/1ps
module sft_fan_ctrl_props
    import sft_pkg::*;
#(
    parameter int TICK_CYCLES = STEP_UNIT_CYC   // clocks per step unit
) (
    input wire logic       sys_clk,              // clock
    input wire logic       srst,                 // sync reset
    input wire logic       host_wr,              // write strobe
    input wire logic       host_rd,              // read strobe
    input wire logic       host_port_sel,        // index or data port
    input wire logic [7:0] host_wdata,           // write data
    input wire logic [7:0] host_rdata,           // read data
    input wire logic [7:0] system_temp_input,    // system sensor
    input wire logic [8:0] primary_temp_input,   // primary sensor
    input wire logic [8:0] auxiliary_temp_input, // aux sensor
    input wire logic       out_strap,            // start strap
    input wire logic [7:0] fan_output_a,         // fan a drive
    input wire logic [7:0] fan_output_b          // fan b drive
);
    logic [6:0] idx_q, idx_d;   // index as the host last wrote it
    logic [2:0] bank_q, bank_d; // bank as the host last chose it
    // shadow the pointer state so data-port accesses can be predicted
    always_comb begin
        idx_d  = idx_q;
        bank_d = bank_q;
        if (host_wr && !host_port_sel) idx_d = host_wdata[6:0];
        if (host_wr && host_port_sel && idx_q == OFS_BANK_SEL) bank_d = host_wdata[2:0];
    end
    always_ff @(posedge sys_clk) begin
        idx_q  <= srst ? 7'h00 : idx_d;
        bank_q <= srst ? BANK_MAIN : bank_d;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    reset_values_a: assert property ($fell(srst) |-> fan_output_a == 8'h80 && fan_output_b == 8'h80 && host_rdata == 8'h00)
        else $error("outputs not at reset value");
    strap_load_a: assert property ($fell(srst) |=> fan_output_a == ($past(out_strap) ? OUT_STRAP_HI : OUT_STRAP_LO))
        else $error("fan a start value wrong");
    strap_load_b_a: assert property ($fell(srst) |=> fan_output_b == ($past(out_strap) ? OUT_STRAP_HI : OUT_STRAP_LO))
        else $error("fan b start value wrong");
    rdata_hold_a: assert property (!host_rd |=> $stable(host_rdata)) else $error("read data moved without read");
    index_read_a: assert property (host_rd && !host_port_sel |=> host_rdata == {1'b0, $past(idx_q)})
        else $error("index port read wrong");
    out_write_a: assert property (host_wr && host_port_sel && idx_q == OFS_OUT[0] && bank_q == BANK_MAIN
        |=> fan_output_a == $past(host_wdata)) else $error("fan a write lost");
    out_write_b_a: assert property (host_wr && host_port_sel && idx_q == OFS_OUT[1] && bank_q == BANK_MAIN
        |=> fan_output_b == $past(host_wdata)) else $error("fan b write lost");
    out_read_a: assert property (host_rd && host_port_sel && idx_q == OFS_OUT[0] && bank_q == BANK_MAIN
        |=> host_rdata == $past(fan_output_a)) else $error("fan a readback wrong");
    // up and down steps come once per tick at most, but a zero stop time turns the fan off the clock after a step
    step_once_a: assert property ($changed(fan_output_a) && !$past(host_wr) && !host_wr |=> $stable(fan_output_a))
        else $error("fan a stepped twice in a row");
    step_once_b_a: assert property ($changed(fan_output_b) && !$past(host_wr) && !host_wr |=> $stable(fan_output_b))
        else $error("fan b stepped twice in a row");
    cover property (!$past(host_wr) && fan_output_a > $past(fan_output_a));
    cover property (!$past(host_wr) && fan_output_b < $past(fan_output_b));
    cover property (fan_output_a == 8'h00 && $past(fan_output_a) == 8'h80);
endmodule
bind sft_fan_ctrl sft_fan_ctrl_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.sys_clk(sys_clk), .srst(srst),
    .host_wr(host_wr), .host_rd(host_rd), .host_port_sel(host_port_sel), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .system_temp_input(system_temp_input), .primary_temp_input(primary_temp_input),
    .auxiliary_temp_input(auxiliary_temp_input), .out_strap(out_strap), .fan_output_a(fan_output_a),
    .fan_output_b(fan_output_b));

/* test/sft_sensor_model.sv */
`timescale 1ns/1ps
module sft_sensor_model (
    input  wire logic       sys_clk,              // clock
    output logic      [7:0] system_temp_input,    // system sensor, whole degrees
    output logic      [8:0] primary_temp_input,   // primary sensor, half at lsb
    output logic      [8:0] auxiliary_temp_input  // aux sensor, half at lsb
);
    logic [7:0] deg_q [3] = '{8'h00, 8'h00, 8'h00}; // whole degrees set by the bench
    logic       half_q    = 1'b0;                   // toggles: regulation must ignore it
    // readings change only at falling edges, away from the sampling edge
    task automatic set_temp(input int which, input logic [7:0] deg);
        @(negedge sys_clk);
        deg_q[which] = deg;
    endtask
    always @(negedge sys_clk) half_q <= ~half_q;
    assign system_temp_input    = deg_q[0];
    assign primary_temp_input   = {deg_q[1], half_q};
    assign auxiliary_temp_input = {deg_q[2], ~half_q};
endmodule

/* test/sft_fan_ctrl_tb.sv */
`timescale 1ns/1ps
module sft_fan_ctrl_tb;
    import sft_pkg::*;
    logic       sys_clk = 1'b0, srst = 1'b1, host_wr = 1'b0, host_rd = 1'b0, host_port_sel = 1'b0, out_strap = 1'b1;
    logic [7:0] host_wdata = 8'h00, host_rdata, fan_output_a, fan_output_b, system_temp_input, rd_val;
    logic [8:0] primary_temp_input, auxiliary_temp_input;
    int         err_total = 0, samples_checked = 0;
    always #5 sys_clk = ~sys_clk;
    sft_sensor_model SENS (.sys_clk(sys_clk), .system_temp_input(system_temp_input),
        .primary_temp_input(primary_temp_input), .auxiliary_temp_input(auxiliary_temp_input));
    // a four-cycle step unit keeps the run short
    sft_fan_ctrl #(.TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .srst(srst), .host_wr(host_wr), .host_rd(host_rd),
        .host_port_sel(host_port_sel), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .system_temp_input(system_temp_input), .primary_temp_input(primary_temp_input),
        .auxiliary_temp_input(auxiliary_temp_input), .out_strap(out_strap),
        .fan_output_a(fan_output_a), .fan_output_b(fan_output_b));
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one strobe per port access, dropped a cycle later
    task automatic wr_port(input logic sel, input logic [7:0] val);
        @(negedge sys_clk);
        host_wr = 1'b1;
        host_port_sel = sel;
        host_wdata = val;
        @(negedge sys_clk);
        host_wr = 1'b0;
    endtask
    task automatic rd_port(input logic sel, output logic [7:0] val);
        @(negedge sys_clk);
        host_rd = 1'b1;
        host_port_sel = sel;
        @(negedge sys_clk);
        host_rd = 1'b0;
        val = host_rdata;
    endtask
    task automatic wr_reg(input logic [6:0] idx, input logic [7:0] val);
        wr_port(1'b0, {1'b0, idx});
        wr_port(1'b1, val);
    endtask
    task automatic chk_reg(input string what, input logic [6:0] idx, input logic [7:0] exp);
        logic [7:0] got;
        wr_port(1'b0, {1'b0, idx});
        rd_port(1'b1, got);
        check8(what, exp, got);
    endtask
    // poll a fan output under a bounded count
    task automatic wait_fan(input logic fb, input logic [7:0] exp, input int lim);
        int n = 0;
        while ((fb ? fan_output_b : fan_output_a) !== exp && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        check8(fb ? "fan b" : "fan a", exp, fb ? fan_output_b : fan_output_a);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog: the sequence needs roughly 3.5 us
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        repeat (2) @(negedge sys_clk);
        check8("strap a", 8'hff, fan_output_a);
        check8("strap b", 8'hff, fan_output_b);
        chk_reg("max a", OFS_MAX[0], RST_MAX);
        chk_reg("step b", OFS_STEP[1], RST_STEP);
        SENS.set_temp(0, 8'd40);
        wr_reg(OFS_SYS_TEMP, 8'h55);
        chk_reg("sys temp", OFS_SYS_TEMP, 8'd40);
        chk_reg("unmapped", 7'h7f, 8'h00);
        wr_port(1'b0, 8'he7);
        rd_port(1'b0, rd_val);
        check8("index", 8'h67, rd_val);
        // fan a on primary sensor, hot: climbs to max then holds
        SENS.set_temp(1, 8'd60);
        wr_reg(OFS_SEL_A, 8'h01);
        wr_reg(OFS_TARGET[0], 8'd50);
        wr_reg(OFS_TOL[0], 8'h20);
        wr_reg(OFS_STEP[0], 8'h10);
        wr_reg(OFS_MAX[0], 8'ha8);
        wr_reg(OFS_STOPV[0], 8'h80);
        wr_reg(OFS_STOPT[0], 8'h08);
        wr_reg(OFS_OUT[0], 8'h80);
        wr_reg(OFS_CTRL_EN, 8'h01);
        wait_fan(1'b0, 8'ha8, 200);
        SENS.set_temp(1, 8'd56);
        repeat (40) @(negedge sys_clk);
        chk_reg("out a", OFS_OUT[0], 8'ha8);
        chk_reg("target a up", OFS_TARGET[0], 8'd56);
        // cold: down to stop value, held, then off
        SENS.set_temp(1, 8'd40);
        wait_fan(1'b0, 8'h80, 200);
        repeat (16) @(negedge sys_clk);
        check8("stop a", 8'h80, fan_output_a);
        wait_fan(1'b0, 8'h00, 100);
        chk_reg("target a down", OFS_TARGET[0], 8'd50);
        // fan b on aux sensor, paced, floored, kept at minimum
        SENS.set_temp(2, 8'd20);
        SENS.set_temp(0, 8'd90);
        wr_reg(OFS_SEL_B, 8'h40);
        wr_reg(OFS_KEEP_MIN, 8'h40);
        wr_reg(OFS_TOL[1], 8'h03);
        wr_reg(OFS_TARGET[1], 8'd30);
        wr_reg(OFS_STOPV[1], 8'h40);
        wr_reg(OFS_STEP[1], 8'h30);
        wr_reg(OFS_STOPT[1], 8'h01);
        wr_reg(OFS_STEP_DOWN, 8'h02);
        wr_reg(OFS_OUT[1], 8'h60);
        wr_reg(OFS_CTRL_EN, 8'h03);
        repeat (6) @(negedge sys_clk);
        check8("paced b", 8'h60, fan_output_b);
        wait_fan(1'b1, 8'h40, 200);
        repeat (60) @(negedge sys_clk);
        check8("kept b", 8'h40, fan_output_b);
        chk_reg("target b", OFS_TARGET[1], 8'd27);
        // system sensor code on fan a: hot, steps up from zero
        wr_reg(OFS_STEP_UP, 8'h02);
        wr_reg(OFS_SEL_A, 8'h00);
        repeat (6) @(negedge sys_clk);
        check8("paced a", 8'h00, fan_output_a);
        wait_fan(1'b0, 8'h10, 100);
        // second reset with the low strap
        srst = 1'b1;
        out_strap = 1'b0;
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        repeat (2) @(negedge sys_clk);
        check8("strap lo a", 8'h80, fan_output_a);
        check8("strap lo b", 8'h80, fan_output_b);
        chk_reg("target rst", OFS_TARGET[0], RST_ZERO);
        wrap_up();
    end
endmodule
